//--- include/bus_buffer_pkg.sv
package bus_buffer_pkg;

  // ************************************************************
  // Time base
  // ************************************************************
  localparam int CLK_MHZ = 100;
  localparam int CLK_HZ = CLK_MHZ * 1000000;

  // ************************************************************
  // Timing figures and derived cycle counts
  // ************************************************************
  localparam int STUCK_LIMIT_MS = 30;
  localparam int STUCK_LIMIT_CYC = STUCK_LIMIT_MS * 1000 * CLK_MHZ;
  localparam int PRE_WAIT_US = 40;
  localparam int PRE_WAIT_CYC = PRE_WAIT_US * CLK_MHZ;
  localparam int PULSE_HZ = 8500;
  localparam int PULSE_HALF_CYC = CLK_HZ / (2 * PULSE_HZ);
  localparam int IDLE_US = 95;
  localparam int IDLE_CYC = IDLE_US * CLK_MHZ;
  localparam int PULSE_COUNT = 16;
  localparam int STOP_PHASES = 3;

  // ************************************************************
  // Types
  // ************************************************************
  typedef struct packed {
    logic data;
    logic clk;
  } bus_lines_t;

  typedef enum logic [5:0] {
    WAIT_IDLE = 6'h01,
    CONNECTED = 6'h02,
    FAULT_WAIT = 6'h04,
    RECOVER = 6'h08,
    STOP_GEN = 6'h10,
    DISCONN = 6'h20
  } ctrl_state_t;

endpackage

//--- logic/bus_buffer_stuck_recovery_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module bus_buffer_stuck_recovery_ctrl #(
  parameter int STUCK_CYC = bus_buffer_pkg::STUCK_LIMIT_CYC,
  parameter int HALF_CYC = bus_buffer_pkg::PULSE_HALF_CYC,
  parameter int IDLE_CYC = bus_buffer_pkg::IDLE_CYC
) (
  input wire logic clk, // Internal time base.
  input wire logic arst_n, // Power-up lockout reset, active low.
  input wire logic linkClk, // Bus sampling and drive clock.
  input wire logic enable, // Connection enable pin.
  input wire logic inDataIn, // Input-side data wire level.
  output logic inDataOut, // Input-side data drive value.
  output logic inDataOe, // Input-side data pull-down enable.
  input wire logic inClkIn, // Input-side clock wire level.
  output logic inClkOut, // Input-side clock drive value.
  output logic inClkOe, // Input-side clock pull-down enable.
  input wire logic outDataIn, // Output-side data wire level.
  output logic outDataOut, // Output-side data drive value.
  output logic outDataOe, // Output-side data pull-down enable.
  input wire logic outClkIn, // Output-side clock wire level.
  output logic outClkOut, // Output-side clock drive value.
  output logic outClkOe, // Output-side clock pull-down enable.
  output logic readyOut, // Ready drive value.
  output logic readyOe // Ready pull-down enable.
);

  // ************************************************************
  // Functions and synchronisers
  // ************************************************************
  function automatic logic [31:0] satInc(logic [31:0] c, int lim);
    satInc = (c >= 32'(lim)) ? 32'(lim) : c + 32'h1;
  endfunction

  bus_buffer_pkg::bus_lines_t inS, outS, inPrev_q, outPrev_q;
  bus_buffer_pkg::ctrl_state_t state_q;
  logic en, enPrev_q, enRise;
  logic [31:0] inIdleCnt_q, outIdleCnt_q, dataTmr_q, clkTmr_q, tmr_q;
  logic [4:0] pulseCnt_q;
  logic [1:0] stopPh_q;
  logic recClkLow_q, recDataLow_q;
  logic inIdle, outIdle, inStop, outStop, connOk, stuck, halfDone;
  logic isConn, busFree;

  sync2 #(.W(5)) u_pin_sync (
    .clk(clk),
    .arst_n(arst_n),
    .d({enable, inDataIn, inClkIn, outDataIn, outClkIn}),
    .q({en, inS.data, inS.clk, outS.data, outS.clk})
  );

  // ************************************************************
  // Bus condition detection
  // ************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      inPrev_q <= '1;
      outPrev_q <= '1;
      // Matches the synchroniser's reset level, so no false rise.
      enPrev_q <= 1'b1;
    end else begin
      inPrev_q <= inS;
      outPrev_q <= outS;
      enPrev_q <= en;
    end
  end

  assign enRise = en & ~enPrev_q;
  assign inStop = inS.clk & inS.data & ~inPrev_q.data & inPrev_q.clk;
  assign outStop = outS.clk & outS.data & ~outPrev_q.data & outPrev_q.clk;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      inIdleCnt_q <= 32'h0;
      outIdleCnt_q <= 32'h0;
    end else begin
      inIdleCnt_q <= (inS.data & inS.clk) ? satInc(inIdleCnt_q, IDLE_CYC)
                                          : 32'h0;
      outIdleCnt_q <= (outS.data & outS.clk) ?
                      satInc(outIdleCnt_q, IDLE_CYC) : 32'h0;
    end
  end

  assign inIdle = inIdleCnt_q == 32'(IDLE_CYC);
  assign outIdle = outIdleCnt_q == 32'(IDLE_CYC);
  assign connOk = (inIdle & outIdle) | (inStop & outIdle) |
                  (outStop & inIdle);

  // ************************************************************
  // Stuck-low timers, output side only
  // ************************************************************
  // The input side has no timer: a fault there is copied across to
  // the output side while connected, where these timers catch it.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dataTmr_q <= 32'h0;
      clkTmr_q <= 32'h0;
    end else begin
      dataTmr_q <= (outS.data | enRise) ? 32'h0
                   : satInc(dataTmr_q, STUCK_CYC);
      clkTmr_q <= (outS.clk | enRise) ? 32'h0
                  : satInc(clkTmr_q, STUCK_CYC);
    end
  end

  assign stuck = (dataTmr_q == 32'(STUCK_CYC)) |
                 (clkTmr_q == 32'(STUCK_CYC));

  // ************************************************************
  // Connection and recovery sequencer
  // ************************************************************
  assign halfDone = tmr_q == 32'(HALF_CYC - 1);
  assign busFree = ~recClkLow_q & outS.data;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= bus_buffer_pkg::WAIT_IDLE;
    end else begin
      case (state_q)
        bus_buffer_pkg::WAIT_IDLE: begin
          if (en && stuck) begin
            state_q <= bus_buffer_pkg::FAULT_WAIT;
          end else if (en && connOk) begin
            state_q <= bus_buffer_pkg::CONNECTED;
          end
        end
        bus_buffer_pkg::CONNECTED: begin
          if (!en) begin
            state_q <= bus_buffer_pkg::WAIT_IDLE;
          end else if (stuck) begin
            state_q <= bus_buffer_pkg::FAULT_WAIT;
          end
        end
        bus_buffer_pkg::FAULT_WAIT: begin
          if (!en) begin
            state_q <= bus_buffer_pkg::DISCONN;
          end else if (tmr_q == 32'(bus_buffer_pkg::PRE_WAIT_CYC)) begin
            state_q <= bus_buffer_pkg::RECOVER;
          end
        end
        bus_buffer_pkg::RECOVER: begin
          if (!en) begin
            state_q <= bus_buffer_pkg::DISCONN;
          end else if (pulseCnt_q == 5'(bus_buffer_pkg::PULSE_COUNT) ||
                       busFree) begin
            state_q <= bus_buffer_pkg::STOP_GEN;
          end
        end
        bus_buffer_pkg::STOP_GEN: begin
          if (!en || (halfDone &&
              stopPh_q == 2'(bus_buffer_pkg::STOP_PHASES - 1))) begin
            state_q <= bus_buffer_pkg::DISCONN;
          end
        end
        bus_buffer_pkg::DISCONN: begin
          if (enRise) begin
            state_q <= bus_buffer_pkg::CONNECTED;
          end else if (en && connOk) begin
            state_q <= bus_buffer_pkg::CONNECTED;
          end
        end
        default: begin
          state_q <= bus_buffer_pkg::WAIT_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tmr_q <= 32'h0;
    end else if (state_q == bus_buffer_pkg::FAULT_WAIT) begin
      tmr_q <= (tmr_q == 32'(bus_buffer_pkg::PRE_WAIT_CYC)) ? 32'h0
               : tmr_q + 32'h1;
    end else if (state_q == bus_buffer_pkg::RECOVER ||
                 state_q == bus_buffer_pkg::STOP_GEN) begin
      tmr_q <= halfDone ? 32'h0 : tmr_q + 32'h1;
    end else begin
      tmr_q <= 32'h0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      recClkLow_q <= 1'b0;
      pulseCnt_q <= 5'h0;
    end else if (state_q == bus_buffer_pkg::RECOVER) begin
      if (halfDone) begin
        recClkLow_q <= ~recClkLow_q;
        pulseCnt_q <= pulseCnt_q + 5'(recClkLow_q);
      end
    end else begin
      recClkLow_q <= state_q == bus_buffer_pkg::STOP_GEN &&
                     stopPh_q == 2'h0;
      pulseCnt_q <= 5'h0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stopPh_q <= 2'h0;
      recDataLow_q <= 1'b0;
    end else begin
      if (state_q != bus_buffer_pkg::STOP_GEN) begin
        stopPh_q <= 2'h0;
      end else if (halfDone) begin
        stopPh_q <= stopPh_q + 2'h1;
      end
      // Data falls in the same cycle as the clock, then rises with the clock
      // high, which is a stop on the output segment.
      recDataLow_q <= state_q == bus_buffer_pkg::STOP_GEN &&
                      stopPh_q != 2'(bus_buffer_pkg::STOP_PHASES - 1);
    end
  end

  assign isConn = state_q == bus_buffer_pkg::CONNECTED;
  assign readyOut = 1'b0;
  assign readyOe = ~(isConn & en);

  // ************************************************************
  // Link-side drive logic
  // ************************************************************
  bus_buffer_pkg::bus_lines_t inL, outL;
  logic connL, recClkL, recDataL;
  logic noConnL, noRecClkL, noRecDataL;
  logic inDataOe_q, inClkOe_q, outDataOe_q, outClkOe_q;
  logic inDataOe_d, inClkOe_d, outDataOe_d, outClkOe_d;
  logic [1:0] inDataHold_q, inClkHold_q, outDataHold_q, outClkHold_q;

  // A line that we have just released still reads low through its
  // synchroniser for a few link clocks; it is ignored meanwhile, or
  // the two sides would keep re-triggering each other.
  function automatic logic [1:0] holdNext(logic oeQ, logic oeD,
                                          logic [1:0] h);
    if (oeQ && !oeD) begin
      holdNext = 2'h3;
    end else if (h != 2'h0) begin
      holdNext = h - 2'h1;
    end else begin
      holdNext = 2'h0;
    end
  endfunction

  // Carried inverted so that the synchroniser's reset level means idle.
  sync2 #(.W(3)) u_ctrl_sync (
    .clk(linkClk),
    .arst_n(arst_n),
    .d({~isConn, ~recClkLow_q, ~recDataLow_q}),
    .q({noConnL, noRecClkL, noRecDataL})
  );

  assign connL = ~noConnL;
  assign recClkL = ~noRecClkL;
  assign recDataL = ~noRecDataL;

  sync2 #(.W(4)) u_link_sync (
    .clk(linkClk),
    .arst_n(arst_n),
    .d({inDataIn, inClkIn, outDataIn, outClkIn}),
    .q({inL.data, inL.clk, outL.data, outL.clk})
  );

  // A side is copied across only while it is not itself driven
  // by us, otherwise the pair would hold itself low forever.
  always_ff @(posedge linkClk or negedge arst_n) begin
    if (!arst_n) begin
      inDataOe_q <= 1'b0;
      inClkOe_q <= 1'b0;
      outDataOe_q <= 1'b0;
      outClkOe_q <= 1'b0;
    end else begin
      inDataOe_q <= inDataOe_d;
      inClkOe_q <= inClkOe_d;
      outDataOe_q <= outDataOe_d;
      outClkOe_q <= outClkOe_d;
    end
  end

  assign inDataOe_d = connL & ~outL.data & ~outDataOe_q &
                      (outDataHold_q == 2'h0);
  assign inClkOe_d = connL & ~outL.clk & ~outClkOe_q &
                     (outClkHold_q == 2'h0);
  assign outDataOe_d = (connL & ~inL.data & ~inDataOe_q &
                       (inDataHold_q == 2'h0)) | recDataL;
  assign outClkOe_d = (connL & ~inL.clk & ~inClkOe_q &
                      (inClkHold_q == 2'h0)) | recClkL;

  always_ff @(posedge linkClk or negedge arst_n) begin
    if (!arst_n) begin
      inDataHold_q <= 2'h0;
      inClkHold_q <= 2'h0;
      outDataHold_q <= 2'h0;
      outClkHold_q <= 2'h0;
    end else begin
      inDataHold_q <= holdNext(inDataOe_q, inDataOe_d, inDataHold_q);
      inClkHold_q <= holdNext(inClkOe_q, inClkOe_d, inClkHold_q);
      outDataHold_q <= holdNext(outDataOe_q, outDataOe_d, outDataHold_q);
      outClkHold_q <= holdNext(outClkOe_q, outClkOe_d, outClkHold_q);
    end
  end

  assign inDataOe = inDataOe_q;
  assign inClkOe = inClkOe_q;
  assign outDataOe = outDataOe_q;
  assign outClkOe = outClkOe_q;
  assign inDataOut = 1'b0;
  assign inClkOut = 1'b0;
  assign outDataOut = 1'b0;
  assign outClkOut = 1'b0;

  // ************************************************************
  // Assertions
  // ************************************************************
  a_timeout_break: assert property (
    @(posedge clk) disable iff (!arst_n)
    (isConn && en && stuck) |=> state_q == bus_buffer_pkg::FAULT_WAIT)
    else $error("stuck line did not break the connection");
  a_enoff_isolate: assert property (
    @(posedge clk) disable iff (!arst_n)
    !en |=> !isConn)
    else $error("connected while enable low");
  a_enoff_norecover: assert property (
    @(posedge clk) disable iff (!arst_n)
    !en |=> !(state_q inside {bus_buffer_pkg::RECOVER,
                              bus_buffer_pkg::STOP_GEN}))
    else $error("recovery running while enable low");
  a_rise_reconnect: assert property (
    @(posedge clk) disable iff (!arst_n)
    (state_q == bus_buffer_pkg::DISCONN && enRise) |=> isConn)
    else $error("enable rise did not reconnect");
  a_ready_enoff: assert property (
    @(posedge clk) disable iff (!arst_n)
    !en |-> readyOe)
    else $error("ready released while enable low");
  a_ready_startup: assert property (
    @(posedge clk) disable iff (!arst_n)
    state_q == bus_buffer_pkg::WAIT_IDLE |-> readyOe)
    else $error("ready released before first connection");
  a_ready_fault: assert property (
    @(posedge clk) disable iff (!arst_n)
    state_q == bus_buffer_pkg::DISCONN |-> readyOe)
    else $error("ready released during fault disconnect");
  a_ready_connected: assert property (
    @(posedge clk) disable iff (!arst_n)
    !readyOe |-> (isConn && en))
    else $error("ready released while not connected");
  a_connect_cond: assert property (
    @(posedge clk) disable iff (!arst_n)
    (state_q == bus_buffer_pkg::WAIT_IDLE ##1 isConn) |-> $past(connOk))
    else $error("connected without idle or stop");
  a_timer_count: assert property (
    @(posedge clk) disable iff (!arst_n)
    (!outS.clk && !enRise && clkTmr_q < 32'(STUCK_CYC)) ##1 !outS.clk
    |-> clkTmr_q == $past(clkTmr_q) + 32'h1)
    else $error("clock stuck timer failed to advance");
  a_pulse_limit: assert property (
    @(posedge clk) disable iff (!arst_n)
    state_q == bus_buffer_pkg::RECOVER |->
    pulseCnt_q <= 5'(bus_buffer_pkg::PULSE_COUNT))
    else $error("more than sixteen recovery pulses");
  a_in_isolated: assert property (
    @(posedge linkClk) disable iff (!arst_n)
    !connL |=> (!inDataOe_q && !inClkOe_q))
    else $error("input side driven while not connected");
  a_wired_and: assert property (
    @(posedge linkClk) disable iff (!arst_n)
    (connL && !inL.data && !inDataOe_q && inDataHold_q == 2'h0)
    |=> outDataOe_q)
    else $error("input data low not copied to output side");

endmodule
`default_nettype wire

//--- logic/sync2.sv
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  input wire logic clk, // Destination clock.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic [W-1:0] d, // Asynchronous level in.
  output logic [W-1:0] q // Synchronised level out.
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '1;
      q <= '1;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule
`default_nettype wire

//--- sim/tb_bus_buffer_stuck_recovery_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module tb_bus_buffer_stuck_recovery_ctrl;
  localparam int STUCK = 200;
  localparam int HALF = 10;
  localparam int IDLE = 20;
  localparam int PRE = 4000;
  logic clk = 1'b0;
  logic linkClk = 1'b0;
  logic arst_n = 1'b0;
  logic enable = 1'b0;
  bus_buffer_pkg::bus_lines_t inPull = '0;
  bus_buffer_pkg::bus_lines_t outPull = '0;
  wire bus_buffer_pkg::bus_lines_t inWire;
  wire bus_buffer_pkg::bus_lines_t outWire;
  wire bus_buffer_pkg::bus_lines_t inOe;
  wire bus_buffer_pkg::bus_lines_t outOe;
  wire logic readyOe;
  int numErrors = 0;
  int numChecks = 0;
  logic [31:0] seed = 32'he8bad1e7;

  initial begin
    forever #5 clk = ~clk;
  end

  // The link clock has its own period and an odd phase offset.
  initial begin
    #7;
    forever #15 linkClk = ~linkClk;
  end

  bus_buffer_stuck_recovery_ctrl #(.STUCK_CYC(STUCK), .HALF_CYC(HALF),
      .IDLE_CYC(IDLE)) dut_u (
    .clk(clk), .arst_n(arst_n), .linkClk(linkClk), .enable(enable),
    .inDataIn(inWire.data), .inDataOut(), .inDataOe(inOe.data),
    .inClkIn(inWire.clk), .inClkOut(), .inClkOe(inOe.clk),
    .outDataIn(outWire.data), .outDataOut(), .outDataOe(outOe.data),
    .outClkIn(outWire.clk), .outClkOut(), .outClkOe(outOe.clk),
    .readyOut(), .readyOe(readyOe)
  );

  two_wire_devices far_u (
    .linkClk(linkClk), .inPull(inPull), .outPull(outPull), .inOe(inOe),
    .outOe(outOe), .inWire(inWire), .outWire(outWire)
  );

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic rnd(output logic [31:0] r);
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    r = seed;
  endtask

  // While bridged, the far side shows exactly the line pulled low.
  function automatic logic [1:0] farLevel(input logic [1:0] m);
    return ~m;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      numErrors++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic waitReady(input logic lvl, input int lim, output int n);
    n = 0;
    while (readyOe !== lvl && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic completeRun;
    $display("checks %0d errors %0d", numChecks, numErrors);
    if (numErrors == 0 && numChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #400000;
    numErrors++;
    completeRun();
  end

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    int n;
    int i;
    int rises;
    int first;
    logic [31:0] r;
    bus_buffer_pkg::bus_lines_t m;
    bus_buffer_pkg::bus_lines_t far;
    logic prev;
    logic touched;
    logic dRose;
    repeat (3) @(negedge clk);
    chk(readyOe, 32'h1);
    @(posedge clk) arst_n <= 1'b1;
    repeat (60) @(negedge clk);
    chk(readyOe, 32'h1);
    @(posedge clk) inPull <= 2'b11;
    repeat (30) @(negedge clk);
    chk({inOe, outOe}, 32'h0);
    chk(outWire, 32'h3);
    @(posedge clk) enable <= 1'b1;
    repeat (30) @(negedge clk);
    chk(readyOe, 32'h1);
    // Both lines rise together: no stop, so only idle may connect.
    @(posedge clk) inPull <= 2'b00;
    waitReady(1'b0, 300, n);
    chk(readyOe, 32'h0);
    chk(n >= IDLE, 32'h1);
    $display("test startup done");
    for (i = 0; i < 24; i++) begin
      rnd(r);
      m = r[0] ? 2'b01 : 2'b10;
      @(posedge clk);
      if (r[1]) outPull <= m;
      else inPull <= m;
      repeat (20 + r[5:2]) @(negedge clk);
      far = r[1] ? inWire : outWire;
      chk(far, farLevel(m));
      @(posedge clk) inPull <= 2'b00;
      outPull <= 2'b00;
      repeat (20) @(negedge clk);
      chk({inWire, outWire}, 32'hf);
    end
    $display("test bridging done");
    @(posedge clk) outPull <= 2'b10;
    waitReady(1'b1, STUCK + 40, n);
    chk(n >= STUCK && n <= STUCK + 12, 32'h1);
    rises = 0;
    first = -1;
    prev = 1'b0;
    touched = 1'b0;
    dRose = 1'b0;
    for (n = 0; n < PRE + 34 * HALF + 100; n++) begin
      @(negedge clk);
      if (outOe.clk && !prev) begin
        rises++;
        if (first < 0) first = n;
      end
      prev = outOe.clk;
      dRose |= outOe.data;
      // The link side needs a few link clocks to see the break.
      if (n >= 20) touched |= inOe.data | inOe.clk | ~readyOe;
    end
    chk(first >= PRE, 32'h1);
    chk(rises == 16 || rises == 17, 32'h1);
    chk(dRose, 32'h1);
    chk(touched, 32'h0);
    $display("test recovery done");
    @(posedge clk) enable <= 1'b0;
    repeat (10) @(negedge clk);
    chk(readyOe, 32'h1);
    @(posedge clk) enable <= 1'b1;
    waitReady(1'b0, 30, n);
    chk(readyOe, 32'h0);
    repeat (20) @(negedge clk);
    chk(inWire.data, 32'h0);
    waitReady(1'b1, STUCK + 60, n);
    chk(readyOe, 32'h1);
    @(posedge clk) enable <= 1'b0;
    rises = 0;
    prev = 1'b0;
    for (n = 0; n < PRE + 1000; n++) begin
      @(negedge clk);
      if (outOe.clk && !prev) rises++;
      prev = outOe.clk;
    end
    chk(rises, 32'h0);
    chk(inOe, 32'h0);
    $display("test enable override done");
    @(posedge clk) outPull <= 2'b00;
    repeat (10) @(posedge clk);
    enable <= 1'b1;
    waitReady(1'b0, 300, n);
    chk(readyOe, 32'h0);
    $display("test reconnect done");
    completeRun();
  end
endmodule
`default_nettype wire

//--- sim/two_wire_devices.sv
`timescale 1ns/1ps
`default_nettype none
module two_wire_devices (
  input wire logic linkClk, // Devices change their lines on this clock.
  input wire bus_buffer_pkg::bus_lines_t inPull, // Input-side pulls low.
  input wire bus_buffer_pkg::bus_lines_t outPull, // Output-side pulls low.
  input wire bus_buffer_pkg::bus_lines_t inOe, // Buffer pulls, input side.
  input wire bus_buffer_pkg::bus_lines_t outOe, // Buffer pulls, output side.
  output wire bus_buffer_pkg::bus_lines_t inWire, // Input-side levels.
  output wire bus_buffer_pkg::bus_lines_t outWire // Output-side levels.
);
  bus_buffer_pkg::bus_lines_t inPull_q = '0;
  bus_buffer_pkg::bus_lines_t outPull_q = '0;

  // Devices move only after a link edge, never in step with the time base.
  always @(posedge linkClk) begin
    inPull_q <= inPull;
    outPull_q <= outPull;
  end

  // Every line has a pull-up, so a released line reads high at once.
  assign inWire = ~(inPull_q | inOe);
  assign outWire = ~(outPull_q | outOe);
endmodule
`default_nettype wire
